// >>> bsc_cfg.svh
// Constants of the boundary-scan test port: codes, widths, reset values.
// Assumes inclusion by the package, the top module and the bench.
//
// Functional notes
// RL1: Instruction register is three bits, shifted LSB first; its code picks operation and path.
// RL2: Identification register shifts out on TDO LSB first, one bit per shift.
// RL3: Identification register is 32 bits: maker 1-11, part 12-27, revision 28-31.
// RL4: Identification bit 0 is always one, so it appears first on TDO.
// RL5: Bypass register is one bit, the shortest path from TDI to TDO.
// RL6: Input cells capture and can impose pin values; output cells control pins.
// RL7: Bidirectional cells sample as inputs and control the pin as outputs.
// RL8: Each bidirectional pin group has a control cell giving its enable in test.
// RL9: Chain positions run 128 down to 1; position 1 lies next to TDO.
// RL10: TAP controller has sixteen states, moving only on rising TCK by TMS.
// RL11: State graph has a data branch and an instruction branch, chosen by TMS.
// RL12: Codes 000 external test, 010 sample/preload, 001 identification.
// RL13: Code 111 bypass, 100 clamp via bypass, 101 outputs high impedance, 011 reserved.
// RL14: Five rising TCK with TMS high force reset state; reset loads identification code.
// RL15: Boundary outputs latch on falling TCK in update-data state only.
// RL16: Bypass bit captures zero in capture-data state.
// RL17: Outside external test, clamp and high impedance, cells pass functional signals.

`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

`define BSC_IR_WIDTH 3
`define BSC_ID_WIDTH 32
`define BSC_CHAIN_LEN 128

`define BSC_IR_EXTEST 3'h0
`define BSC_IR_IDCODE 3'h1
`define BSC_IR_SAMPLE 3'h2
`define BSC_IR_RESVD 3'h3
`define BSC_IR_CLAMP 3'h4
`define BSC_IR_HIGHZ 3'h5
`define BSC_IR_BYPASS 3'h7
`define BSC_IR_CAPTURE 3'h1

`define BSC_ID_FIXED_POS 0
`define BSC_ID_MAKER_LSB 1
`define BSC_ID_PART_LSB 12
`define BSC_ID_REV_LSB 28
// Arbitrary identity values, not any real part
`define BSC_ID_MAKER 11'h2a5
`define BSC_ID_PART 16'h1234
`define BSC_ID_REV 4'h1

`define BSC_CELL_IN_MASK 128'hff0000ff_9fffffc0_00000000_2db6db7f
`define BSC_RESET_TMS_RISES 3'h5

`endif

// >>> bsc_pkg.sv
// Types of the boundary-scan test port.
// Assumes bsc_cfg.svh is on the include path.
`include "bsc_cfg.svh"

package bsc_pkg;
  typedef enum logic [15:0] {
    st_tlr = 16'h0001,
    st_rti = 16'h0002,
    st_sel_dr = 16'h0004,
    st_cap_dr = 16'h0008,
    st_shf_dr = 16'h0010,
    st_ex1_dr = 16'h0020,
    st_pau_dr = 16'h0040,
    st_ex2_dr = 16'h0080,
    st_upd_dr = 16'h0100,
    st_sel_ir = 16'h0200,
    st_cap_ir = 16'h0400,
    st_shf_ir = 16'h0800,
    st_ex1_ir = 16'h1000,
    st_pau_ir = 16'h2000,
    st_ex2_ir = 16'h4000,
    st_upd_ir = 16'h8000
  } bsc_state_type;

  typedef logic [`BSC_IR_WIDTH-1:0] bsc_instr_type;
endpackage : bsc_pkg

// >>> bsc_sync.sv
// Two-stage synchroniser for pin levels entering the mclk_i domain.
// Assumes inputs are plain levels; no consumer reads the first stage.
`timescale 1ns/1ps

module bsc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  if (WIDTH < 1) begin : g_chk
    $error("bsc_sync width must be positive");
  end

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule : bsc_sync

// >>> bsc_tap_fsm.sv
// Sixteen-state TAP controller, stepped by a sampled rising TCK.
// Assumes tck_rise_i is a one-cycle pulse aligned with a stable tms_i.
`timescale 1ns/1ps

module bsc_tap_fsm (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic tck_rise_i,
  input wire logic tms_i,
  output bsc_pkg::bsc_state_type state_o
);
  import bsc_pkg::*;

  bsc_state_type state_reg;
  bsc_state_type state_next;

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    if (tck_rise_i) begin // see RL10
      case (state_reg) // see RL11
        st_tlr: state_next = tms_i ? st_tlr : st_rti;
        st_rti: state_next = tms_i ? st_sel_dr : st_rti;
        st_sel_dr: state_next = tms_i ? st_sel_ir : st_cap_dr;
        st_cap_dr: state_next = tms_i ? st_ex1_dr : st_shf_dr;
        st_shf_dr: state_next = tms_i ? st_ex1_dr : st_shf_dr;
        st_ex1_dr: state_next = tms_i ? st_upd_dr : st_pau_dr;
        st_pau_dr: state_next = tms_i ? st_ex2_dr : st_pau_dr;
        st_ex2_dr: state_next = tms_i ? st_upd_dr : st_shf_dr;
        st_upd_dr: state_next = tms_i ? st_sel_dr : st_rti;
        st_sel_ir: state_next = tms_i ? st_tlr : st_cap_ir;
        st_cap_ir: state_next = tms_i ? st_ex1_ir : st_shf_ir;
        st_shf_ir: state_next = tms_i ? st_ex1_ir : st_shf_ir;
        st_ex1_ir: state_next = tms_i ? st_upd_ir : st_pau_ir;
        st_pau_ir: state_next = tms_i ? st_ex2_ir : st_pau_ir;
        st_ex2_ir: state_next = tms_i ? st_upd_ir : st_shf_ir;
        st_upd_ir: state_next = tms_i ? st_sel_dr : st_rti;
        default: state_next = st_tlr;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_reg <= st_tlr;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

  // ==========================================================
  // Checks
  chk_state_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RL10
    !tck_rise_i |=> $stable(state_reg))
    else $error("TAP state moved without a rising TCK");

  chk_branch_pick: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RL11
    (tck_rise_i && state_reg == st_sel_dr) |=> (state_reg == (tms_i ? st_sel_ir : st_cap_dr)))
    else $error("Wrong branch taken from data select");
endmodule : bsc_tap_fsm

// >>> bsc_top.sv
// Boundary-scan test port: TAP, instruction, identification, bypass, boundary chain.
// Assumes TCK, TMS, TDI come from pins; core and pin vectors sit on mclk_i.
`timescale 1ns/1ps
`include "bsc_cfg.svh"

module bsc_top #(
  parameter int CHAIN_LEN = `BSC_CHAIN_LEN,
  parameter logic [`BSC_CHAIN_LEN-1:0] CELL_IN_MASK = `BSC_CELL_IN_MASK
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [CHAIN_LEN-1:0] pin_in_i,
  input wire logic [CHAIN_LEN-1:0] core_out_i,
  output logic [CHAIN_LEN-1:0] pin_out_o,
  output logic [CHAIN_LEN-1:0] core_in_o,
  output logic pin_hiz_o
);
  import bsc_pkg::*;

  if (CHAIN_LEN != `BSC_CHAIN_LEN) begin : g_chk
    $error("boundary chain length must match the cell mask");
  end

  // ==========================================================
  // Pin sampling and TCK edges
  logic [2:0] pins_sync;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d_reg;
  logic tck_d_next;
  logic tck_rise;
  logic tck_fall;
  bsc_state_type state;

  bsc_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .async_i({tck_i, tms_i, tdi_i}),
    .sync_o(pins_sync)
  );

  assign tck_s = pins_sync[2];
  assign tms_s = pins_sync[1];
  assign tdi_s = pins_sync[0];
  assign tck_rise = tck_s && !tck_d_reg;
  assign tck_fall = !tck_s && tck_d_reg;

  always_comb begin
    tck_d_next = tck_s;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tck_d_reg <= 1'b0;
    end else begin
      tck_d_reg <= tck_d_next;
    end
  end

  bsc_tap_fsm u_fsm (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .tck_rise_i(tck_rise),
    .tms_i(tms_s),
    .state_o(state)
  );

  // ==========================================================
  // Instruction register
  bsc_instr_type ir_sh_reg;
  bsc_instr_type ir_sh_next;
  bsc_instr_type ir_reg;
  bsc_instr_type ir_next;
  logic chain_sel;
  logic id_sel;
  logic drive_test;
  logic core_test;

  always_comb begin
    ir_sh_next = ir_sh_reg;
    ir_next = ir_reg;
    if (state == st_tlr) begin
      ir_sh_next = `BSC_IR_IDCODE; // see RL14
      ir_next = `BSC_IR_IDCODE; // see RL14
    end else if (tck_rise && state == st_cap_ir) begin
      ir_sh_next = `BSC_IR_CAPTURE;
    end else if (tck_rise && state == st_shf_ir) begin
      ir_sh_next = {tdi_s, ir_sh_reg[`BSC_IR_WIDTH-1:1]}; // see RL1
    end else if (tck_fall && state == st_upd_ir) begin
      ir_next = ir_sh_reg; // see RL1
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ir_sh_reg <= `BSC_IR_IDCODE;
      ir_reg <= `BSC_IR_IDCODE;
    end else begin
      ir_sh_reg <= ir_sh_next;
      ir_reg <= ir_next;
    end
  end

  // Reserved code falls through to bypass, keeping the chain short
  assign chain_sel = (ir_reg == `BSC_IR_EXTEST) || (ir_reg == `BSC_IR_SAMPLE); // see RL12
  assign id_sel = (ir_reg == `BSC_IR_IDCODE); // see RL12
  assign drive_test = (ir_reg == `BSC_IR_EXTEST) || (ir_reg == `BSC_IR_CLAMP); // see RL13
  assign core_test = (ir_reg == `BSC_IR_EXTEST);

  // ==========================================================
  // Identification and bypass registers
  logic [`BSC_ID_WIDTH-1:0] id_sh_reg;
  logic [`BSC_ID_WIDTH-1:0] id_sh_next;
  logic [`BSC_ID_WIDTH-1:0] id_value;
  logic byp_reg;
  logic byp_next;

  always_comb begin
    id_value = '0;
    id_value[`BSC_ID_FIXED_POS] = 1'b1; // see RL4
    id_value[`BSC_ID_MAKER_LSB +: 11] = `BSC_ID_MAKER; // see RL3
    id_value[`BSC_ID_PART_LSB +: 16] = `BSC_ID_PART; // see RL3
    id_value[`BSC_ID_REV_LSB +: 4] = `BSC_ID_REV; // see RL3
  end

  always_comb begin
    id_sh_next = id_sh_reg;
    byp_next = byp_reg;
    if (tck_rise && state == st_cap_dr) begin
      if (id_sel) begin
        id_sh_next = id_value;
      end
      if (!chain_sel && !id_sel) begin
        byp_next = 1'b0; // see RL16
      end
    end else if (tck_rise && state == st_shf_dr) begin
      if (id_sel) begin
        id_sh_next = {tdi_s, id_sh_reg[`BSC_ID_WIDTH-1:1]}; // see RL2
      end
      if (!chain_sel && !id_sel) begin
        byp_next = tdi_s; // see RL5
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      id_sh_reg <= '0;
      byp_reg <= 1'b0;
    end else begin
      id_sh_reg <= id_sh_next;
      byp_reg <= byp_next;
    end
  end

  // ==========================================================
  // Boundary chain; bit index is position minus one
  logic [CHAIN_LEN-1:0] chain_sh_reg;
  logic [CHAIN_LEN-1:0] chain_sh_next;
  logic [CHAIN_LEN-1:0] chain_upd_reg;
  logic [CHAIN_LEN-1:0] chain_upd_next;
  logic [CHAIN_LEN-1:0] cell_cap;
  logic [CHAIN_LEN-1:0] pin_out_reg;
  logic [CHAIN_LEN-1:0] pin_out_next;
  logic [CHAIN_LEN-1:0] core_in_reg;
  logic [CHAIN_LEN-1:0] core_in_next;
  logic pin_hiz_reg;
  logic pin_hiz_next;

  for (genvar i = 0; i < CHAIN_LEN; i++) begin : g_cell
    // Input and bidirectional cells watch the pin; output and control cells the core
    assign cell_cap[i] = CELL_IN_MASK[i] ? pin_in_i[i] : core_out_i[i]; // see RL6
    always_comb begin
      pin_out_next[i] = drive_test ? chain_upd_reg[i] : core_out_i[i]; // see RL7
      core_in_next[i] = core_test ? chain_upd_reg[i] : pin_in_i[i]; // see RL17
    end
  end

  always_comb begin
    chain_sh_next = chain_sh_reg;
    chain_upd_next = chain_upd_reg;
    pin_hiz_next = (ir_reg == `BSC_IR_HIGHZ); // see RL13
    if (chain_sel && tck_rise && state == st_cap_dr) begin
      chain_sh_next = cell_cap; // see RL6
    end else if (chain_sel && tck_rise && state == st_shf_dr) begin
      chain_sh_next = {tdi_s, chain_sh_reg[CHAIN_LEN-1:1]}; // see RL9
    end
    if (chain_sel && tck_fall && state == st_upd_dr) begin
      chain_upd_next = chain_sh_reg; // see RL15
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      chain_sh_reg <= '0;
      chain_upd_reg <= '0;
      pin_out_reg <= '0;
      core_in_reg <= '0;
      pin_hiz_reg <= 1'b0;
    end else begin
      chain_sh_reg <= chain_sh_next;
      chain_upd_reg <= chain_upd_next;
      pin_out_reg <= pin_out_next; // see RL8
      core_in_reg <= core_in_next;
      pin_hiz_reg <= pin_hiz_next;
    end
  end

  assign pin_out_o = pin_out_reg;
  assign core_in_o = core_in_reg;
  assign pin_hiz_o = pin_hiz_reg;

  // ==========================================================
  // TDO changes on falling TCK, so the tester samples a settled bit
  logic tdo_reg;
  logic tdo_next;
  logic tdo_oe_reg;
  logic tdo_oe_next;
  logic shifting;
  logic serial_out;

  assign shifting = (state == st_shf_dr) || (state == st_shf_ir);

  always_comb begin
    if (state == st_shf_ir) begin
      serial_out = ir_sh_reg[0];
    end else if (chain_sel) begin
      serial_out = chain_sh_reg[0]; // see RL9
    end else if (id_sel) begin
      serial_out = id_sh_reg[0]; // see RL2
    end else begin
      serial_out = byp_reg; // see RL5
    end
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_fall) begin
      tdo_next = shifting ? serial_out : 1'b0;
      tdo_oe_next = shifting;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;

  // ==========================================================
  // Checks
  logic [2:0] tms_hi_reg;
  logic [2:0] tms_hi_next;

  always_comb begin
    tms_hi_next = tms_hi_reg;
    if (tck_rise) begin
      tms_hi_next = !tms_s ? 3'h0 :
        (tms_hi_reg == `BSC_RESET_TMS_RISES) ? tms_hi_reg : tms_hi_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tms_hi_reg <= 3'h0;
    end else begin
      tms_hi_reg <= tms_hi_next;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  chk_tms_reset: assert property (tms_hi_reg == `BSC_RESET_TMS_RISES // see RL14
    |-> state == st_tlr)
    else $error("Five TMS-high edges did not reach reset state");

  chk_reset_idcode: assert property (state == st_tlr |=> ir_reg == `BSC_IR_IDCODE) // see RL14
    else $error("Reset state did not load identification code");

  chk_ir_shift_lsb: assert property ((tck_rise && state == st_shf_ir) // see RL1
    |=> ir_sh_reg == {$past(tdi_s), $past(ir_sh_reg[2:1])})
    else $error("Instruction shift order wrong");

  chk_id_first_one: assert property ((tck_rise && state == st_cap_dr && id_sel) // see RL4
    |=> id_sh_reg[0] && id_sh_reg[31:28] == `BSC_ID_REV)
    else $error("Identification capture wrong");

  chk_bypass_zero: assert property (tck_rise && state == st_cap_dr // see RL16
    && ir_reg == `BSC_IR_BYPASS |=> !byp_reg)
    else $error("Bypass did not capture zero");

  // Each Shift-DR fall under the bypass code must present the bypass bit as it stood at that fall
  chk_bypass_path: assert property (tck_fall && state == st_shf_dr // see RL5
    && ir_reg == `BSC_IR_BYPASS |=> tdo_oe_o && tdo_o == $past(byp_reg))
    else $error("Bypass bit not driven on TDO");

  chk_update_only: assert property ($changed(chain_upd_reg) // see RL15
    |-> $past(tck_fall && state == st_upd_dr && chain_sel))
    else $error("Boundary latch changed outside update");

  chk_clamp_hold: assert property (ir_reg == `BSC_IR_CLAMP // see RL13
    && $past(ir_reg) == `BSC_IR_CLAMP |=> pin_out_o == $past(chain_upd_reg))
    else $error("Clamp did not hold pins from chain");

  chk_pass_through: assert property ((ir_reg == `BSC_IR_SAMPLE) // see RL17
    |=> pin_out_o == $past(core_out_i) && core_in_o == $past(pin_in_i))
    else $error("Sample disturbed functional path");

  chk_highz_out: assert property ((ir_reg == `BSC_IR_HIGHZ) // see RL13
    ##1 (ir_reg == `BSC_IR_HIGHZ) |-> pin_hiz_o)
    else $error("High impedance not applied");
endmodule : bsc_top

// >>> bsc_tester.sv
// External boundary-scan controller model driving the TAP pins of the port.
// Assumes a free-running mclk_i; all pin changes land on its falling edge.
`timescale 1ns/1ps

module bsc_tester (
  input wire logic mclk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  import bsc_pkg::*;

  // TCK stands low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b0;
    tdi_o = 1'b0;
  end

  // ==========================================
  // One TCK period of 200 ns
  // TMS and TDI settle 3 mclk before the rise; TDO is taken mid-high phase
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge mclk_i);
    tms_o = tms;
    tdi_o = tdi;
    repeat (3) @(negedge mclk_i);
    tck_o = 1'b1;
    repeat (2) @(negedge mclk_i);
    tdo = tdo_i;
    repeat (2) @(negedge mclk_i);
    tck_o = 1'b0;
  endtask : step

  // Released TDI no longer shows the last bit
  task automatic release_tdi();
    tdi_o = ~tdi_o;
  endtask : release_tdi

  // ==========================================
  // Sequences
  task automatic reset_tap();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask : reset_tap

  // From Run-Test/Idle back to Run-Test/Idle, code LSB first
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic d;
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], cap[i]);
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    release_tdi();
  endtask : load_ir

  task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    release_tdi();
  endtask : scan_dr
endmodule : bsc_tester

// >>> bsc_top_test.sv
// Self-checking bench of the boundary-scan test port.
// Assumes bsc_tester as the external controller and bsc_cfg.svh on the include path.
`timescale 1ns/1ps
`include "bsc_cfg.svh"

module bsc_top_test;
  import bsc_pkg::*;

  localparam logic [127:0] ID_WORD = {96'h0, `BSC_ID_REV, `BSC_ID_PART, `BSC_ID_MAKER, 1'b1};
  localparam logic [127:0] MASK = `BSC_CELL_IN_MASK;
  localparam logic [127:0] PIN_PAT = {4{32'hc3a5_0f96}};
  localparam logic [127:0] CORE_PAT = {4{32'h5a3c_e1f0}};
  localparam logic [127:0] PRE_PAT = {4{32'h9e37_79b9}};

  logic mclk, rstn, tck, tms, tdi, tdo, tdo_oe, tdo_line, pin_hiz;
  logic [127:0] pin_in, core_out, pin_out, core_in, dout, mix;
  logic [2:0] cap;
  int bad_count = 0;
  int tests_run = 0;

  // Pull-up on the TDO line while the port does not drive it
  assign tdo_line = tdo_oe ? tdo : 1'b1;
  assign mix = (MASK & pin_in) | (~MASK & core_out);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  bsc_top dut (.mclk_i(mclk), .rstn_i(rstn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .core_out_i(core_out),
    .pin_out_o(pin_out), .core_in_o(core_in), .pin_hiz_o(pin_hiz));

  bsc_tester ctl (.mclk_i(mclk), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  // ==========================================
  // Compare and report
  task automatic check_vec(input logic [127:0] got, input logic [127:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_vec

  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ==========================================
  // Scenarios
  task automatic t_reset_id();
    ctl.scan_dr(32, 128'h0, dout);
    check_vec({96'h0, dout[31:0]}, ID_WORD, "id word");
    check_bit(tdo_oe, 1'b0, "tdo enable idle");
  endtask : t_reset_id

  // Bypass-like codes: one-bit path, zero captured first
  task automatic t_bypass();
    logic [2:0] codes [3] = '{3'h7, 3'h4, 3'h3};
    for (int k = 0; k < 3; k++) begin
      ctl.load_ir(codes[k], cap);
      check_vec({125'h0, cap}, {125'h0, `BSC_IR_CAPTURE}, "ir capture");
      ctl.scan_dr(8, {120'h0, 8'hb5}, dout);
      check_vec({120'h0, dout[7:0]}, {120'h0, 8'h6a}, "bypass path");
    end
  endtask : t_bypass

  task automatic t_sample();
    ctl.load_ir(`BSC_IR_SAMPLE, cap);
    check_vec(pin_out, core_out, "sample pin out");
    check_vec(core_in, pin_in, "sample core in");
    ctl.scan_dr(128, PRE_PAT, dout);
    check_vec(dout, mix, "sample capture");
    check_vec(pin_out, core_out, "preload hidden");
  endtask : t_sample

  task automatic t_extest();
    ctl.load_ir(`BSC_IR_EXTEST, cap);
    check_vec(pin_out, PRE_PAT, "extest preload pins");
    check_vec(core_in, PRE_PAT, "extest core in");
    ctl.scan_dr(128, ~PRE_PAT, dout);
    check_vec(dout, mix, "extest capture");
    check_vec(pin_out, ~PRE_PAT, "extest update");
  endtask : t_extest

  // Pins frozen even though the core changes its drive
  task automatic t_clamp();
    ctl.load_ir(`BSC_IR_CLAMP, cap);
    @(negedge mclk);
    core_out = ~CORE_PAT;
    repeat (3) @(negedge mclk);
    check_vec(pin_out, ~PRE_PAT, "clamp pins");
    check_vec(core_in, pin_in, "clamp core in");
  endtask : t_clamp

  task automatic t_highz();
    ctl.load_ir(`BSC_IR_HIGHZ, cap);
    check_bit(pin_hiz, 1'b1, "highz on");
    check_vec(pin_out, core_out, "highz pins functional");
    ctl.load_ir(`BSC_IR_BYPASS, cap);
    check_bit(pin_hiz, 1'b0, "highz off");
  endtask : t_highz

  // Five TMS-high rises out of mid Shift-DR restore the identification path
  task automatic t_tap_reset();
    logic d;
    ctl.load_ir(`BSC_IR_EXTEST, cap);
    ctl.step(1'b1, 1'b0, d);
    ctl.step(1'b0, 1'b0, d);
    ctl.step(1'b0, 1'b1, d);
    ctl.step(1'b0, 1'b0, d);
    ctl.reset_tap();
    check_vec(pin_out, core_out, "pins after tap reset");
    t_reset_id();
  endtask : t_tap_reset

  // ==========================================
  // Main sequence and hang guard
  initial begin
    rstn = 1'b0;
    pin_in = PIN_PAT;
    core_out = CORE_PAT;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    ctl.reset_tap();
    t_reset_id();
    t_bypass();
    t_sample();
    t_extest();
    t_clamp();
    t_highz();
    t_tap_reset();
    results();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    $display("Error at %0t ns: run limit reached", $time);
    results();
  end
endmodule : bsc_top_test
